// [src/anr_cfg.svh]
// Behaviour
// - advertisement register readable writable at index 4
// - next-page bit writable, reset 0, no effect
// - acknowledge bit read-only, follows word recognition
// - remote-fault bit resets 0, writable in advertisement
// - four-pair bit writable, resets to 0
// - fast full-duplex bit writable, resets to 1
// - fast half-duplex bit writable, resets to 1
// - slow full-duplex bit writable, resets to 1
// - slow half-duplex bit writable, resets to 1
// - selector bit zero writable, resets to 1
// - partner register read-only at index 5, resets 0
// - register data shifted most significant bit first
`ifndef ANR_CFG_SVH
`define ANR_CFG_SVH

// ----------------------------------------------------------------
// register indices on the management serial port
// ----------------------------------------------------------------
`define ANR_ADV_IDX        5'h04
`define ANR_PTR_IDX        5'h05

// ----------------------------------------------------------------
// field positions, common to both ability registers
// ----------------------------------------------------------------
`define ANR_NEXT_PAGE_BIT  15
`define ANR_ACK_BIT        14
`define ANR_RFAULT_BIT     13
`define ANR_FOUR_PAIR_BIT  9
`define ANR_FAST_FDX_BIT   8
`define ANR_FAST_HDX_BIT   7
`define ANR_SLOW_FDX_BIT   6
`define ANR_SLOW_HDX_BIT   5
`define ANR_SELECTOR_BIT   0

// ----------------------------------------------------------------
// reset values and storage masks
// ----------------------------------------------------------------
`define ANR_ADV_RESET      16'h01e1
`define ANR_PTR_RESET      16'h0000
`define ANR_STORE_MASK     16'ha3e1

// ----------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------
`define ANR_PREAMBLE_LEN   32
`define ANR_HDR_LAST       5'h0c
`define ANR_DATA_LAST      5'h0f
`define ANR_OP_READ        2'h2
`define ANR_OP_WRITE       2'h1

`endif

// [src/anr_pkg.sv]
package anr_pkg;

    // serial frame engine states
    typedef enum logic [1:0] {
        ST_PREAMBLE,
        ST_HEADER,
        ST_TURN,
        ST_DATA
    } anr_state_t;

endpackage

// [src/anr_edge_detect.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// management clock rising edge finder with aligned data sample
// ----------------------------------------------------------------
module anr_edge_detect (
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    input  wire logic mdc_in,
    input  wire logic mdio_in,
    output logic      rise_out,
    output logic      data_out
);

    logic mdc_q; // previous management clock level

    // rising edge pulse and the data bit seen with it
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mdc_q    <= 1'b0;
            rise_out <= 1'b0;
            data_out <= 1'b0;
        end else begin
            mdc_q    <= mdc_in;
            rise_out <= mdc_in & ~mdc_q;
            data_out <= mdio_in;
        end
    end

endmodule // anr_edge_detect

// [src/anr_partner_capture.sv]
`timescale 1ns/1ns
`include "anr_cfg.svh"
// ----------------------------------------------------------------
// partner ability word and acknowledge capture
// ----------------------------------------------------------------
module anr_partner_capture (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic        rx_strobe_in,
    input  wire logic        rx_ok_in,
    input  wire logic [15:0] rx_word_in,
    output logic      [15:0] partner_out,
    output logic             ack_out
);

    logic        take_w; // recognized word arrives
    logic [15:0] keep_w; // stored fields only

    assign take_w = rx_strobe_in & rx_ok_in;
    assign keep_w = rx_word_in & `ANR_STORE_MASK;

    // ack follows recognition of each received word
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ack_out <= 1'b0;
        end else if (rx_strobe_in) begin
            ack_out <= rx_ok_in;
        end
    end

    // partner fields load without any management write
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            partner_out <= `ANR_PTR_RESET;
        end else if (take_w) begin
            partner_out <= keep_w;
        end
    end

endmodule // anr_partner_capture

// [src/anr_ability_regs.sv]
`timescale 1ns/1ns
`include "anr_cfg.svh"
// ----------------------------------------------------------------
// auto-negotiation ability register pair on the serial port
// ----------------------------------------------------------------
module anr_ability_regs #(
    parameter int DATA_W       = 16,
    parameter int PREAMBLE_LEN = `ANR_PREAMBLE_LEN
) (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic        mdc_in,
    input  wire logic        mdio_in,
    input  wire logic [4:0]  phy_addr_in,
    input  wire logic        rx_strobe_in,
    input  wire logic        rx_ok_in,
    input  wire logic [15:0] rx_word_in,
    output logic             mdio_out,
    output logic             mdio_oe_out,
    output logic      [15:0] advert_word_out,
    output logic      [15:0] partner_word_out,
    output logic             ack_out
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (DATA_W != 16) begin : g_bad_width
        $error("register width must be 16");
    end
    if (PREAMBLE_LEN < 1 || PREAMBLE_LEN > 63) begin : g_bad_pre
        $error("preamble length must be 1 to 63");
    end

    localparam logic [5:0] PRE_LEN = 6'(PREAMBLE_LEN);

    // ------------------------------------------------------------
    // read word composer
    // ------------------------------------------------------------
    function automatic logic [15:0] anr_read_word(
        input logic [4:0]  idx,
        input logic [15:0] adv,
        input logic [15:0] ptr,
        input logic        ack
    );
        logic [15:0] w;
        w = (idx == `ANR_ADV_IDX) ? adv : ptr;
        w = w & `ANR_STORE_MASK; // reserved bits read zero
        w[`ANR_ACK_BIT] = ack;
        return w;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    anr_pkg::anr_state_t state_q;     // frame engine state
    anr_pkg::anr_state_t state_d;     // next engine state
    logic [5:0]          ones_q;      // preamble ones seen
    logic [5:0]          ones_d;      // next ones count
    logic [4:0]          cnt_q;       // bit counter in field
    logic [4:0]          cnt_d;       // next bit counter
    logic [11:0]         hdr_q;       // header bits so far
    logic [4:0]          idx_q;       // addressed register
    logic                is_rd_q;     // frame is a read
    logic [15:0]         rd_sh_q;     // outgoing read shifter
    logic [15:0]         rd_word_q;   // word being read
    logic [15:0]         wr_sh_q;     // incoming write shifter
    logic [15:0]         adv_q;       // advertisement storage
    logic [15:0]         adv_d;       // next advertisement
    logic                rise_w;      // management clock rose
    logic                din_w;       // data bit at that edge
    logic [15:0]         ptr_w;       // partner fields
    logic                ack_w;       // acknowledge level

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    anr_edge_detect u_edge (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .mdc_in     (mdc_in),
        .mdio_in    (mdio_in),
        .rise_out   (rise_w),
        .data_out   (din_w)
    );

    anr_partner_capture u_partner (
        .sys_clk_in   (sys_clk_in),
        .reset_in     (reset_in),
        .rx_strobe_in (rx_strobe_in),
        .rx_ok_in     (rx_ok_in),
        .rx_word_in   (rx_word_in),
        .partner_out  (ptr_w),
        .ack_out      (ack_w)
    );

    // ------------------------------------------------------------
    // header decode
    // ------------------------------------------------------------
    logic [12:0] hdr_full_w;  // start, op, phy, register
    logic [1:0]  op_w;        // operation code
    logic [4:0]  phy_w;       // addressed device
    logic [4:0]  reg_w;       // addressed register
    logic        hit_w;       // frame is ours
    logic        hdr_done_w;  // last header bit taken
    logic        data_end_w;  // last data bit taken
    logic        wr_commit_w; // write to advertisement
    logic [15:0] wr_word_w;   // complete write word

    assign hdr_full_w = {hdr_q, din_w};
    assign op_w       = hdr_full_w[11:10];
    assign phy_w      = hdr_full_w[9:5];
    assign reg_w      = hdr_full_w[4:0];
    assign hit_w      = hdr_full_w[12] && phy_w == phy_addr_in
                        && (op_w == `ANR_OP_READ || op_w == `ANR_OP_WRITE)
                        && (reg_w == `ANR_ADV_IDX || reg_w == `ANR_PTR_IDX);
    assign hdr_done_w = rise_w && state_q == anr_pkg::ST_HEADER
                        && cnt_q == `ANR_HDR_LAST;
    assign data_end_w = rise_w && state_q == anr_pkg::ST_DATA
                        && cnt_q == `ANR_DATA_LAST;
    assign wr_word_w  = {wr_sh_q[14:0], din_w};
    assign wr_commit_w = data_end_w && !is_rd_q && idx_q == `ANR_ADV_IDX;

    // writable fields only; ack and reserved bits stay zero
    assign adv_d = wr_commit_w ? (wr_word_w & `ANR_STORE_MASK) : adv_q;

    // ------------------------------------------------------------
    // frame engine next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        ones_d  = ones_q;
        cnt_d   = cnt_q;
        if (rise_w) begin
            unique case (state_q)
                anr_pkg::ST_PREAMBLE: begin
                    cnt_d = 5'h00;
                    if (din_w) begin
                        ones_d = (ones_q == PRE_LEN) ? ones_q : ones_q + 6'h01;
                    end else if (ones_q == PRE_LEN) begin
                        state_d = anr_pkg::ST_HEADER; // first start bit
                        ones_d  = 6'h00;
                    end else begin
                        ones_d = 6'h00;
                    end
                end
                anr_pkg::ST_HEADER: begin
                    cnt_d = cnt_q + 5'h01;
                    if (hdr_done_w) begin
                        cnt_d   = 5'h00;
                        state_d = hit_w ? anr_pkg::ST_TURN : anr_pkg::ST_PREAMBLE;
                    end
                end
                anr_pkg::ST_TURN: begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == 5'h01) begin
                        cnt_d   = 5'h00;
                        state_d = anr_pkg::ST_DATA;
                    end
                end
                anr_pkg::ST_DATA: begin
                    cnt_d = cnt_q + 5'h01;
                    if (data_end_w) begin
                        cnt_d   = 5'h00;
                        state_d = anr_pkg::ST_PREAMBLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // engine registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q <= anr_pkg::ST_PREAMBLE;
            ones_q  <= 6'h00;
            cnt_q   <= 5'h00;
        end else begin
            state_q <= state_d;
            ones_q  <= ones_d;
            cnt_q   <= cnt_d;
        end
    end

    // header shifter and frame attributes
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            hdr_q   <= 12'h000;
            idx_q   <= 5'h00;
            is_rd_q <= 1'b0;
        end else if (rise_w && state_q == anr_pkg::ST_HEADER) begin
            hdr_q <= hdr_full_w[11:0];
            if (hdr_done_w) begin
                idx_q   <= reg_w;
                is_rd_q <= op_w == `ANR_OP_READ;
            end
        end
    end

    // ------------------------------------------------------------
    // read path: load at header end, shift out top bit first
    // ------------------------------------------------------------
    logic [15:0] rd_load_w; // word for the addressed register

    assign rd_load_w = anr_read_word(reg_w, adv_q, ptr_w, ack_w);

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_sh_q   <= 16'h0000;
            rd_word_q <= 16'h0000;
        end else if (hdr_done_w) begin
            rd_sh_q   <= rd_load_w;
            rd_word_q <= rd_load_w;
        end else if (rise_w && is_rd_q && state_q != anr_pkg::ST_PREAMBLE
                     && state_q != anr_pkg::ST_HEADER && mdio_oe_out
                     && !(state_q == anr_pkg::ST_TURN && cnt_q == 5'h00)) begin
            rd_sh_q <= {rd_sh_q[14:0], 1'b0};
        end
    end

    // pin drive: turnaround zero, then data, release after bit 0
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mdio_out    <= 1'b0;
            mdio_oe_out <= 1'b0;
        end else if (rise_w && is_rd_q && state_q == anr_pkg::ST_TURN) begin
            mdio_oe_out <= 1'b1;
            mdio_out    <= (cnt_q == 5'h00) ? 1'b0 : rd_sh_q[15];
        end else if (data_end_w) begin
            mdio_oe_out <= 1'b0;
            mdio_out    <= 1'b0;
        end else if (rise_w && is_rd_q && state_q == anr_pkg::ST_DATA) begin
            mdio_out <= rd_sh_q[15];
        end
    end

    // ------------------------------------------------------------
    // write path and advertisement storage
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_sh_q <= 16'h0000;
        end else if (rise_w && state_q == anr_pkg::ST_DATA) begin
            wr_sh_q <= wr_word_w;
        end
    end

    // next-page bit is held only; no next-page exchange exists
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            adv_q <= `ANR_ADV_RESET;
        end else begin
            adv_q <= adv_d;
        end
    end

    // ------------------------------------------------------------
    // outputs to the negotiation engine
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            advert_word_out  <= `ANR_ADV_RESET;
            partner_word_out <= `ANR_PTR_RESET;
            ack_out          <= 1'b0;
        end else begin
            advert_word_out  <= adv_q;
            partner_word_out <= anr_read_word(`ANR_PTR_IDX, adv_q, ptr_w, ack_w);
            ack_out          <= ack_w;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_turn_end;
        rise_w && is_rd_q && state_q == anr_pkg::ST_TURN && cnt_q == 5'h01;
    endsequence

    property p_adv_write;
        wr_commit_w |=> ##1 advert_word_out == (($past(wr_word_w, 2)) & `ANR_STORE_MASK);
    endproperty
    a_adv_write: assert property (p_adv_write) else $error("advert write lost");

    property p_np_hold;
        !wr_commit_w |=> adv_q[15] == $past(adv_q[15]);
    endproperty
    a_np_hold: assert property (p_np_hold) else $error("next page bit moved");

    property p_ack_follow;
        rx_strobe_in |=> ##1 ack_out == $past(rx_ok_in, 2);
    endproperty
    a_ack_follow: assert property (p_ack_follow) else $error("ack not following word");

    property p_rf_write;
        wr_commit_w && !wr_word_w[13] |=> !adv_q[13];
    endproperty
    a_rf_write: assert property (p_rf_write) else $error("remote fault not cleared");

    property p_reset_vals;
        $fell(reset_in) |-> adv_q == 16'h01e1 && ptr_w == 16'h0000;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

    property p_partner_load;
        rx_strobe_in && rx_ok_in |=> ##1 partner_word_out[15:0] == ((
            $past(rx_word_in, 2) & 16'ha3e1) | 16'h4000);
    endproperty
    a_partner_load: assert property (p_partner_load) else $error("partner word not loaded");

    property p_msb_first;
        s_turn_end |=> mdio_oe_out && mdio_out == rd_word_q[15];
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("read not msb first");

    property p_reserved_zero;
        hdr_done_w |=> (rd_word_q & 16'h1c1e) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_turn_zero;
        $rose(mdio_oe_out) |-> !mdio_out;
    endproperty
    a_turn_zero: assert property (p_turn_zero) else $error("turnaround not zero");

endmodule // anr_ability_regs

// [verification/anr_mgmt_model.sv]
`timescale 1ns/1ns
`include "anr_cfg.svh"
// ----------------------------------------------------------------
// station management controller model, mdc/mdio frame master
// ----------------------------------------------------------------
module anr_mgmt_model (
    input  wire logic sys_clk_in,   // paces the mdc phases
    input  wire logic mdio_in,      // resolved line, pulled up
    output logic      mdc_out,      // management clock, still between frames
    output logic      mdio_out,     // data from the controller
    output logic      mdio_oe_out   // high while the controller drives
);
    int half = 3;                   // sys_clk cycles per mdc phase, 3 fast, 5 slow

    // idle: line released, clock parked
    initial begin
        mdc_out     = 1'b0;
        mdio_out    = 1'b1;
        mdio_oe_out = 1'b0;
    end

    // one mdc period: drive in the low phase, sample at the rise
    task automatic one_bit(input logic b, input logic drv, output logic s);
        @(posedge sys_clk_in);
        #2;
        mdc_out     = 1'b0;
        mdio_out    = b;
        mdio_oe_out = drv;
        repeat (half) @(posedge sys_clk_in);
        #2;
        s       = mdio_in;
        mdc_out = 1'b1;
        repeat (half - 1) @(posedge sys_clk_in);
    endtask

    // whole frame: preamble, header, turnaround, 16 data bits
    task automatic frame(input logic [13:0] hdr, input logic [15:0] wd,
                         output logic ta2, output logic [15:0] rd);
        logic wr;
        logic s;
        wr = (hdr[11:10] == `ANR_OP_WRITE);
        for (int i = 0; i < `ANR_PREAMBLE_LEN; i++)
            one_bit(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--)
            one_bit(hdr[i], 1'b1, s);
        one_bit(1'b1, wr, s);
        one_bit(1'b0, wr, ta2);
        for (int i = 15; i >= 0; i--) begin
            one_bit(wd[i], wr, s);
            rd[i] = s;
        end
        // let go of the line, park the clock low as after reset
        @(posedge sys_clk_in);
        #2;
        mdio_oe_out = 1'b0;
        mdc_out     = 1'b0;
        repeat (4) @(posedge sys_clk_in);
    endtask
endmodule // anr_mgmt_model

// [verification/tb.sv]
`timescale 1ns/1ns
`include "anr_cfg.svh"
// compare two values, count, report at once
`define CHK(act, exp) begin \
    checks_done++; \
    if ((act) !== (exp)) begin \
        miscompares++; \
        $display("BAD t=%0t got %h exp %h", $time, act, exp); \
    end \
end
// ----------------------------------------------------------------
// ability register bench
// ----------------------------------------------------------------
module tb;
    logic        sys_clk_in;        // 50 MHz
    logic        reset_in;          // async, active high
    logic [4:0]  phy_addr_in;       // device address
    logic        rx_strobe_in;      // negotiation word present
    logic        rx_ok_in;          // word recognised
    logic [15:0] rx_word_in;        // received word
    wire         mdc;               // management clock
    wire         m_d;               // controller data
    wire         m_oe;              // controller drives
    wire         mdio_out;          // device data
    wire         mdio_oe_out;       // device drives
    wire  [15:0] advert_word_out;   // advertisement storage
    wire  [15:0] partner_word_out;  // partner register
    wire         ack_out;           // acknowledge level
    wire         mdio_line;         // resolved line
    logic [15:0] adv_m;             // expected advertisement
    logic [15:0] ptr_m;             // expected partner fields
    logic        ack_m;             // expected acknowledge
    logic [31:0] lfsr;              // random source
    int          oe_seen;           // cycles with device driving
    int          miscompares;
    int          checks_done;

    // pull-up when nobody drives
    assign mdio_line = mdio_oe_out ? mdio_out : (m_oe ? m_d : 1'b1);

    anr_ability_regs DUT (
        .sys_clk_in       (sys_clk_in),
        .reset_in         (reset_in),
        .mdc_in           (mdc),
        .mdio_in          (mdio_line),
        .phy_addr_in      (phy_addr_in),
        .rx_strobe_in     (rx_strobe_in),
        .rx_ok_in         (rx_ok_in),
        .rx_word_in       (rx_word_in),
        .mdio_out         (mdio_out),
        .mdio_oe_out      (mdio_oe_out),
        .advert_word_out  (advert_word_out),
        .partner_word_out (partner_word_out),
        .ack_out          (ack_out)
    );

    anr_mgmt_model mgr (
        .sys_clk_in  (sys_clk_in),
        .mdio_in     (mdio_line),
        .mdc_out     (mdc),
        .mdio_out    (m_d),
        .mdio_oe_out (m_oe)
    );

    // ----------------------------------------------------------------
    // clock, watchdog, drive monitor
    // ----------------------------------------------------------------
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    initial begin
        repeat (100000) @(posedge sys_clk_in);
        miscompares++;
        print_verdict();
    end

    always @(posedge sys_clk_in) begin
        if (mdio_oe_out !== 1'b0)
            oe_seen <= oe_seen + 1;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0);
    endfunction

    // serial read value, ack shows in both registers
    function automatic logic [15:0] exp_read(input logic [4:0] idx);
        if (idx == `ANR_ADV_IDX)
            return adv_m | {1'b0, ack_m, 14'h0};
        return ptr_m | {1'b0, ack_m, 14'h0};
    endfunction

    task automatic rd_chk(input logic [4:0] idx);
        logic        ta;
        logic [15:0] d;
        mgr.frame({2'b01, `ANR_OP_READ, phy_addr_in, idx}, 16'h0, ta, d);
        `CHK(ta, 1'b0)
        `CHK(d, exp_read(idx))
        `CHK(mdio_oe_out, 1'b0)
    endtask

    task automatic wr_reg(input logic [4:0] idx, input logic [15:0] d);
        logic        ta;
        logic [15:0] q;
        mgr.frame({2'b01, `ANR_OP_WRITE, phy_addr_in, idx}, d, ta, q);
    endtask

    // refused frame: nothing driven, line stays pulled up
    task automatic ref_chk(input logic [13:0] hdr);
        logic        ta;
        logic [15:0] d;
        int          seen;
        seen = oe_seen;
        mgr.frame(hdr, 16'h0, ta, d);
        `CHK(d, 16'hffff)
        `CHK(oe_seen, seen)
    endtask

    // negotiation word, answer two edges after the strobe
    task automatic neg_word(input logic ok, input logic [15:0] w);
        @(posedge sys_clk_in);
        #2;
        rx_strobe_in = 1'b1;
        rx_ok_in     = ok;
        rx_word_in   = w;
        @(posedge sys_clk_in);
        #2;
        rx_strobe_in = 1'b0;
        rx_word_in   = ~w;
        ack_m        = ok;
        if (ok)
            ptr_m = w & `ANR_STORE_MASK;
        @(posedge sys_clk_in);
        @(posedge sys_clk_in);
        #2;
        `CHK(ack_out, ack_m)
        `CHK(partner_word_out, ptr_m | {1'b0, ack_m, 14'h0})
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] d;
        reset_in     = 1'b1;
        phy_addr_in  = 5'h0b;
        rx_strobe_in = 1'b0;
        rx_ok_in     = 1'b0;
        rx_word_in   = 16'h0;
        adv_m        = `ANR_ADV_RESET;
        ptr_m        = 16'h0;
        ack_m        = 1'b0;
        lfsr         = 32'h0001_7187;
        oe_seen      = 0;
        miscompares  = 0;
        checks_done  = 0;
        repeat (16) @(posedge sys_clk_in);
        #2;
        reset_in = 1'b0;
        // reset values at the ports and over the wire
        `CHK(advert_word_out[15], 1'b0)
        `CHK(advert_word_out[13], 1'b0)
        `CHK(advert_word_out[9], 1'b0)
        `CHK(advert_word_out[8:5], 4'hf)
        `CHK(advert_word_out[0], 1'b1)
        `CHK(partner_word_out, 16'h0)
        rd_chk(`ANR_ADV_IDX);
        rd_chk(`ANR_PTR_IDX);
        $display("test reset done");
        // writes: all ones, all zeros, then random
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            d = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : lfsr[15:0];
            wr_reg(`ANR_ADV_IDX, d);
            adv_m = d & `ANR_STORE_MASK;
            `CHK(advert_word_out, adv_m)
            rd_chk(`ANR_ADV_IDX);
        end
        wr_reg(`ANR_PTR_IDX, 16'hffff);
        rd_chk(`ANR_PTR_IDX);
        $display("test write done");
        // negotiation words, recognised and not
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            neg_word((i == 1) ? 1'b0 : (i == 0) || lfsr[16], (i == 0) ? 16'hffff : lfsr[15:0]);
            rd_chk(`ANR_PTR_IDX);
            rd_chk(`ANR_ADV_IDX);
        end
        $display("test negotiation done");
        // refused frames: wrong address, other index, bad start, bad opcode
        lfsr = lfsr_next(lfsr);
        phy_addr_in = lfsr[4:0];
        ref_chk({2'b01, `ANR_OP_READ, ~phy_addr_in, `ANR_ADV_IDX});
        ref_chk({2'b01, `ANR_OP_READ, phy_addr_in, 5'h06});
        ref_chk({2'b00, `ANR_OP_READ, phy_addr_in, `ANR_PTR_IDX});
        ref_chk({2'b01, 2'h3, phy_addr_in, `ANR_ADV_IDX});
        rd_chk(`ANR_PTR_IDX);
        $display("test refused done");
        // slow controller
        mgr.half = 5;
        rd_chk(`ANR_ADV_IDX);
        mgr.half = 3;
        $display("test slow done");
        // second reset mid-run
        @(posedge sys_clk_in);
        #2;
        reset_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        #2;
        reset_in = 1'b0;
        adv_m = `ANR_ADV_RESET;
        ptr_m = 16'h0;
        ack_m = 1'b0;
        `CHK(advert_word_out, `ANR_ADV_RESET)
        `CHK(ack_out, 1'b0)
        rd_chk(`ANR_PTR_IDX);
        $display("test rereset done");
        print_verdict();
    end
endmodule // tb
